// >>> pta_pkg.sv
package pta_pkg;

    // ---------------------------------------------------------------
    // command codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_VENDOR_FAULT_STATUS = 8'h80;
    localparam logic [7:0] CMD_INPUT_VOLTAGE_READING = 8'h88;
    localparam logic [7:0] CMD_INPUT_CURRENT_READING = 8'h89;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_READING = 8'h8B;
    localparam logic [7:0] CMD_OUTPUT_CURRENT_READING = 8'h8C;
    localparam logic [7:0] CMD_TEMPERATURE_READING = 8'h8D;
    localparam logic [7:0] CMD_OUTPUT_POWER_READING = 8'h96;
    localparam logic [7:0] CMD_RATED_INPUT_VOLTAGE_MIN = 8'hA0;
    localparam logic [7:0] CMD_RATED_INPUT_VOLTAGE_MAX = 8'hA1;
    localparam logic [7:0] CMD_RATED_OUTPUT_VOLTAGE_MIN = 8'hA4;
    localparam logic [7:0] CMD_RATED_OUTPUT_VOLTAGE_MAX = 8'hA5;
    localparam logic [7:0] CMD_RATED_OUTPUT_CURRENT_MAX = 8'hA6;
    localparam logic [7:0] CMD_RATED_OUTPUT_POWER_MAX = 8'hA7;
    localparam logic [7:0] CMD_ENABLE_INPUT_POLARITY = 8'hD0;
    localparam logic [7:0] CMD_TURNS_RATIO_READING = 8'hD1;
    localparam logic [7:0] CMD_OUTPUT_RESISTANCE_READING = 8'hD4;
    localparam logic [7:0] CMD_COMBINED_LIMIT_WRITE = 8'hD5;
    localparam logic [7:0] CMD_SUPERVISORY_FAULT_MASK = 8'hD7;

    // ---------------------------------------------------------------
    // page values
    // ---------------------------------------------------------------
    localparam logic [7:0] PAGE_SUPERVISOR = 8'h00;
    localparam logic [7:0] PAGE_LAST_MODULE = 8'h04;
    localparam logic [7:0] PAGE_BROADCAST = 8'hFF;

    // ---------------------------------------------------------------
    // vendor status bit positions and reset values
    // ---------------------------------------------------------------
    localparam int STS_REVERSE_BIT = 7;
    localparam int STS_ANALOG_SHUTDOWN_BIT = 6;
    localparam int STS_LINK_COMM_BIT = 5;
    localparam logic [7:0] PERCENT_MAX = 8'h64;
    localparam logic [7:0] PERCENT_RESET = 8'h64;
    localparam logic [7:0] POLARITY_RESET = 8'h01;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] MASK_UV_BIT = 8'h10;

    // ---------------------------------------------------------------
    // per-module telemetry snapshot as delivered by the link side
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [15:0] vin;
        logic [15:0] iin;
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] temp;
        logic [15:0] pout;
        logic [15:0] kfac;
        logic [15:0] rout;
        logic reverse;
        logic analog_fault;
        logic sup_event;
    } pta_telem_t;

    // command request from the host transport
    typedef struct packed {
        logic [7:0] code;
        logic [47:0] data;
        logic wr;
    } pta_cmd_t;

endpackage

// >>> pta_link_sync.sv
// carries a module telemetry word from the link clock domain by handshake
module pta_link_sync #(
    parameter int W = 136
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic [W-1:0] link_data,
    input wire logic link_valid,
    output logic [W-1:0] sys_data,
    output logic sys_pulse
);
    logic [W-1:0] hold;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    wire idle = (req == ack_s2);

    // link side: capture a word only when the last one was acknowledged
    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold <= '0;
            req <= 1'b0;
        end
        else if (link_valid && idle)
        begin
            hold <= link_data;
            req <= ~req;
        end
    end

    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end
        else
        begin
            ack_s1 <= req_s2;
            ack_s2 <= ack_s1;
        end
    end

    // system side: hold stays stable while the toggle travels
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            sys_data <= '0;
            sys_pulse <= 1'b0;
        end
        else
        begin
            req_s1 <= req;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            sys_pulse <= req_s2 ^ req_s3;
            if (req_s2 != req_s3)
                sys_data <= hold;
        end
    end

endmodule

// >>> pta_combine.sv
// folds per-module words into sum, max, min over the active set
module pta_combine #(
    parameter int N = 4
)
(
    input wire logic [N*16-1:0] vals,
    input wire logic [N-1:0] active,
    input wire logic is_signed,
    output logic [15:0] sum,
    output logic [15:0] max,
    output logic [15:0] min
);
    logic [15:0] s [N+1];
    logic [15:0] mx [N+1];
    logic [15:0] mn [N+1];
    assign s[0] = 16'h0000;
    assign mx[0] = 16'h0000;
    assign mn[0] = 16'hFFFF;
    genvar i;
    // max starts from zero, so empty set reads zero for both modes
    generate
        for (i = 0; i < N; i++)
        begin : g_fold
            wire [15:0] v = vals[i*16 +: 16];
            wire gt = is_signed ? ($signed(v) > $signed(mx[i])) : (v > mx[i]);
            assign s[i+1] = active[i] ? 16'(s[i] + v) : s[i];
            assign mx[i+1] = (active[i] && (gt || i == 0 || mx[i] == 0
                && !(|active[i-1 < 0 ? 0 : i-1:0]))) ? v : mx[i];
            assign mn[i+1] = (active[i] && v < mn[i]) ? v : mn[i];
        end
    endgenerate
    assign sum = s[N];
    assign max = mx[N];
    assign min = (|active) ? mn[N] : 16'h0000;
endmodule

// >>> pta_top.sv
// Function
// - reverse current sets reverse bit, no magnitude
// - any powertrain protection fault sets shutdown bit
// - masked supervisory fault event sets shutdown bit
// - supervisor page ORs three bits over active
// - silent active module after contact sets comm fault
// - comm fault clears on recovery; clear faults clears it only once module disabled
// - input voltage in tenths of volt
// - input current per module, sum on supervisor
// - output voltage in tenths of volt
// - output current hundredths, sum on supervisor
// - signed temperature, max on supervisor
// - output power watts, sum on supervisor
// - ratings are fixed read-only values
// - ratings combine highest min, lowest max, sum
// - settings writable only while all modules disabled
// - polarity one starts on input voltage alone
// - polarity zero needs enable pulled low
// - limits default full scale, only lowered
// - limit byte above maximum percent leaves unchanged
// - mask bit disables that supervisory fault
// - mask spares analog protections and limit warnings
// - undervoltage disable only lowers to floor
// - page zero supervisor, one to four, broadcast
module pta_top #(
    parameter int N = 4,
    parameter int SILENCE_CYCLES = 100000,
    parameter logic [15:0] RATED_VIN_MIN = 16'h0104,
    parameter logic [15:0] RATED_VIN_MAX = 16'h0186,
    parameter logic [15:0] RATED_VOUT_MIN = 16'h0020,
    parameter logic [15:0] RATED_VOUT_MAX = 16'h0031,
    parameter logic [15:0] RATED_IOUT_MAX = 16'h0023,
    parameter logic [15:0] RATED_POUT_MAX = 16'h06A4
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic [N-1:0] link_valid,
    input wire pta_pkg::pta_telem_t link_telem [N],
    input wire logic [N-1:0] module_enabled,
    input wire logic [N-1:0] enable_pin_n_raw,
    input wire logic [N-1:0] uv_ok_raw,
    input wire logic cmd_valid,
    input wire pta_pkg::pta_cmd_t cmd,
    output logic [15:0] rsp_data,
    output logic rsp_valid,
    output logic cml_error,
    output logic [N-1:0] module_start,
    output logic [N-1:0] uv_floor_only,
    output logic [N*24-1:0] limit_pct
);
    // ---------------------------------------------------------------
    // crossings
    // ---------------------------------------------------------------
    pta_pkg::pta_telem_t tel [N];
    logic [N-1:0] tel_pulse;
    logic [N-1:0] en_s1;
    logic [N-1:0] en_s2;
    logic [N-1:0] uv_s1;
    logic [N-1:0] uv_s2;
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_sync
            pta_link_sync #(.W($bits(pta_pkg::pta_telem_t))) u_sync (
                .clk(clk),
                .arst_n(arst_n),
                .link_clk(link_clk),
                .link_data(link_telem[g]),
                .link_valid(link_valid[g]),
                .sys_data(tel[g]),
                .sys_pulse(tel_pulse[g])
            );
        end
    endgenerate

    // pin levels come from outside: two stages before use
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_s1 <= '0;
            en_s2 <= '0;
            uv_s1 <= '0;
            uv_s2 <= '0;
        end
        else if (ce)
        begin
            en_s1 <= enable_pin_n_raw;
            en_s2 <= en_s1;
            uv_s1 <= uv_ok_raw;
            uv_s2 <= uv_s1;
        end
    end

    // ---------------------------------------------------------------
    // page and settings
    // ---------------------------------------------------------------
    logic [7:0] page;
    logic [7:0] polarity [N];
    logic [7:0] fault_mask [N];
    logic [47:0] limits [N];
    wire all_disabled = ~|module_enabled;
    wire is_wr = cmd_valid && cmd.wr && ce;
    wire page_sup = (page == pta_pkg::PAGE_SUPERVISOR);
    wire page_bc = (page == pta_pkg::PAGE_BROADCAST);
    wire page_mod = (page != pta_pkg::PAGE_SUPERVISOR)
        && (page <= pta_pkg::PAGE_LAST_MODULE);
    wire [1:0] sel = 2'(page - 8'h01);
    wire nv_cmd = (cmd.code == pta_pkg::CMD_ENABLE_INPUT_POLARITY)
        || (cmd.code == pta_pkg::CMD_COMBINED_LIMIT_WRITE)
        || (cmd.code == pta_pkg::CMD_SUPERVISORY_FAULT_MASK);
    wire nv_ok = is_wr && nv_cmd && all_disabled;
    wire nv_refused = is_wr && nv_cmd && !all_disabled;
    wire clr_sup = is_wr && (cmd.code == pta_pkg::CMD_CLEAR_FAULTS)
        && page_sup;
    wire clr_mod = is_wr && (cmd.code == pta_pkg::CMD_CLEAR_FAULTS);

    // page register itself
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            page <= pta_pkg::PAGE_SUPERVISOR;
        else if (is_wr && cmd.code == pta_pkg::CMD_PAGE)
            page <= cmd.data[7:0];
    end

    // refused settings write raises a sticky communication error
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cml_error <= 1'b0;
        else if (nv_refused)
            cml_error <= 1'b1;
        else if (clr_mod)
            cml_error <= 1'b0;
    end

    // ---------------------------------------------------------------
    // per-module settings, status and link watchdog
    // ---------------------------------------------------------------
    logic [7:0] vstat [N];
    logic [N-1:0] seen;
    logic [31:0] quiet [N];
    generate
        for (g = 0; g < N; g++)
        begin : g_mod
            wire hit = page_bc || (page_mod && sel == 2'(g));
            wire wr_here = nv_ok && hit;
            wire [7:0] lb [6];
            for (genvar b = 0; b < 6; b++)
            begin : g_lim
                // bytes above full scale keep the old value
                assign lb[b] = (cmd.data[b*8 +: 8] > pta_pkg::PERCENT_MAX)
                    ? limits[g][b*8 +: 8] : cmd.data[b*8 +: 8];
            end

            // stored settings; limits reset to full scale
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    polarity[g] <= pta_pkg::POLARITY_RESET;
                    fault_mask[g] <= pta_pkg::MASK_RESET;
                    limits[g] <= {6{pta_pkg::PERCENT_RESET}};
                end
                else if (wr_here)
                begin
                    case (cmd.code)
                        pta_pkg::CMD_ENABLE_INPUT_POLARITY:
                            polarity[g] <= cmd.data[7:0];
                        pta_pkg::CMD_SUPERVISORY_FAULT_MASK:
                            fault_mask[g] <= cmd.data[7:0];
                        pta_pkg::CMD_COMBINED_LIMIT_WRITE:
                            limits[g] <= {lb[5], lb[4], lb[3], lb[2],
                                lb[1], lb[0]};
                        default:
                            limits[g] <= limits[g];
                    endcase
                end
            end

            // masked events still reach the analog shutdown bit
            wire masked_evt = tel_pulse[g] && tel[g].sup_event
                && (|fault_mask[g]);
            wire timeout = seen[g] && module_enabled[g]
                && (quiet[g] >= 32'(SILENCE_CYCLES));
            wire set_rev = tel_pulse[g] && tel[g].reverse;
            wire set_an = (tel_pulse[g] && tel[g].analog_fault)
                || masked_evt;
            wire clr_bits = clr_sup || (clr_mod && hit);
            wire [7:0] w1c = (is_wr && hit
                && cmd.code == pta_pkg::CMD_VENDOR_FAULT_STATUS)
                ? cmd.data[7:0] : 8'h00;

            // sticky bits; a set in the same cycle beats any clear, except a new word, which beats a timeout on the comm bit
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    vstat[g] <= 8'h00;
                else if (ce)
                begin
                    vstat[g][pta_pkg::STS_REVERSE_BIT] <= set_rev
                        || (vstat[g][pta_pkg::STS_REVERSE_BIT] && !clr_bits
                        && !w1c[pta_pkg::STS_REVERSE_BIT]);
                    vstat[g][pta_pkg::STS_ANALOG_SHUTDOWN_BIT] <= set_an
                        || (vstat[g][pta_pkg::STS_ANALOG_SHUTDOWN_BIT]
                        && !clr_bits
                        && !w1c[pta_pkg::STS_ANALOG_SHUTDOWN_BIT]);
                    vstat[g][pta_pkg::STS_LINK_COMM_BIT] <= !tel_pulse[g]
                        && (timeout || (vstat[g][pta_pkg::STS_LINK_COMM_BIT]
                        && !clr_bits
                        && !w1c[pta_pkg::STS_LINK_COMM_BIT]));
                end
            end

            // silence counter only counts after a first contact
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    seen[g] <= 1'b0;
                    quiet[g] <= '0;
                end
                else if (ce)
                begin
                    if (tel_pulse[g])
                    begin
                        seen[g] <= 1'b1;
                        quiet[g] <= '0;
                    end
                    else if (seen[g] && quiet[g] < 32'(SILENCE_CYCLES))
                        quiet[g] <= quiet[g] + 32'd1;
                end
            end

            // start logic from polarity and the synced enable pin
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    module_start[g] <= 1'b0;
                else if (ce)
                    module_start[g] <= uv_s2[g] && (polarity[g][0]
                        || !en_s2[g]);
            end

            // masking undervoltage only moves the trip to the floor
            assign uv_floor_only[g] = |(fault_mask[g]
                & pta_pkg::MASK_UV_BIT);
            assign limit_pct[g*24 +: 24] = {limits[g][40 +: 8],
                limits[g][24 +: 8], limits[g][8 +: 8]};
        end
    endgenerate

    // ---------------------------------------------------------------
    // aggregate views
    // ---------------------------------------------------------------
    logic [N*16-1:0] v_iin;
    logic [N*16-1:0] v_iout;
    logic [N*16-1:0] v_temp;
    logic [N*16-1:0] v_pout;
    logic [7:0] or_stat;
    generate
        for (g = 0; g < N; g++)
        begin : g_pack
            assign v_iin[g*16 +: 16] = tel[g].iin;
            assign v_iout[g*16 +: 16] = tel[g].iout;
            assign v_temp[g*16 +: 16] = tel[g].temp;
            assign v_pout[g*16 +: 16] = tel[g].pout;
        end
    endgenerate

    // OR of the three flags across active modules
    always_comb
    begin
        or_stat = 8'h00;
        for (int k = 0; k < N; k++)
            if (module_enabled[k])
                or_stat = or_stat | vstat[k];
    end

    logic [15:0] s_iin;
    logic [15:0] s_iout;
    logic [15:0] s_pout;
    logic [15:0] m_temp;
    pta_combine #(.N(N)) u_iin (.vals(v_iin), .active(module_enabled),
        .is_signed(1'b0), .sum(s_iin), .max(), .min());
    pta_combine #(.N(N)) u_iout (.vals(v_iout), .active(module_enabled),
        .is_signed(1'b0), .sum(s_iout), .max(), .min());
    pta_combine #(.N(N)) u_pout (.vals(v_pout), .active(module_enabled),
        .is_signed(1'b0), .sum(s_pout), .max(), .min());
    pta_combine #(.N(N)) u_temp (.vals(v_temp), .active(module_enabled),
        .is_signed(1'b1), .sum(), .max(m_temp), .min());

    // identical fixed ratings: min/max is the value, sum scales
    wire [2:0] n_act = 3'($countones(module_enabled));
    wire [15:0] sum_iout_rate = 16'(RATED_IOUT_MAX * n_act);
    wire [15:0] sum_pout_rate = 16'(RATED_POUT_MAX * n_act);
    pta_pkg::pta_telem_t cur;
    assign cur = tel[sel];

    // ---------------------------------------------------------------
    // read decode
    // ---------------------------------------------------------------
    logic [15:0] next_rsp;
    always_comb
    begin
        next_rsp = 16'h0000;
        case (cmd.code)
            pta_pkg::CMD_PAGE: next_rsp = {8'h00, page};
            pta_pkg::CMD_VENDOR_FAULT_STATUS:
                next_rsp = {8'h00, page_sup ? or_stat : vstat[sel]};
            pta_pkg::CMD_INPUT_VOLTAGE_READING: next_rsp = cur.vin;
            pta_pkg::CMD_INPUT_CURRENT_READING:
                next_rsp = page_sup ? s_iin : cur.iin;
            pta_pkg::CMD_OUTPUT_VOLTAGE_READING: next_rsp = cur.vout;
            pta_pkg::CMD_OUTPUT_CURRENT_READING:
                next_rsp = page_sup ? s_iout : cur.iout;
            pta_pkg::CMD_TEMPERATURE_READING:
                next_rsp = page_sup ? m_temp : cur.temp;
            pta_pkg::CMD_OUTPUT_POWER_READING:
                next_rsp = page_sup ? s_pout : cur.pout;
            pta_pkg::CMD_RATED_INPUT_VOLTAGE_MIN: next_rsp = RATED_VIN_MIN;
            pta_pkg::CMD_RATED_INPUT_VOLTAGE_MAX: next_rsp = RATED_VIN_MAX;
            pta_pkg::CMD_RATED_OUTPUT_VOLTAGE_MIN: next_rsp = RATED_VOUT_MIN;
            pta_pkg::CMD_RATED_OUTPUT_VOLTAGE_MAX: next_rsp = RATED_VOUT_MAX;
            pta_pkg::CMD_RATED_OUTPUT_CURRENT_MAX:
                next_rsp = page_sup ? sum_iout_rate : RATED_IOUT_MAX;
            pta_pkg::CMD_RATED_OUTPUT_POWER_MAX:
                next_rsp = page_sup ? sum_pout_rate : RATED_POUT_MAX;
            pta_pkg::CMD_ENABLE_INPUT_POLARITY:
                next_rsp = {8'h00, polarity[sel]};
            pta_pkg::CMD_TURNS_RATIO_READING: next_rsp = cur.kfac;
            pta_pkg::CMD_OUTPUT_RESISTANCE_READING: next_rsp = cur.rout;
            pta_pkg::CMD_SUPERVISORY_FAULT_MASK:
                next_rsp = {8'h00, fault_mask[sel]};
            default: next_rsp = 16'h0000;
        endcase
    end

    // answer one cycle after a read request
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rsp_data <= 16'h0000;
            rsp_valid <= 1'b0;
        end
        else if (ce)
        begin
            rsp_valid <= cmd_valid && !cmd.wr;
            if (cmd_valid && !cmd.wr)
                rsp_data <= next_rsp;
        end
    end
endmodule

// >>> pta_conv_model.sv
// converter-module side of the links: sends one telemetry word per request
module pta_conv_model #(
    parameter int N = 4
)
(
    input wire logic link_clk,
    input wire logic go,
    input wire pta_pkg::pta_telem_t tel [N],
    output logic [N-1:0] link_valid,
    output pta_pkg::pta_telem_t link_telem [N]
);
    // -----------------------------------------------------------
    // link driver
    // -----------------------------------------------------------
    // between words the data is inverted every link clock, so stale values recur every other cycle
    initial link_valid = '0;
    always @(posedge link_clk)
    begin
        link_valid <= {N{go}};
        for (int i = 0; i < N; i++)
            link_telem[i] <= go ? tel[i] : ~link_telem[i];
    end
endmodule

// >>> pta_top_checker.sv
module pta_top_checker #(
    parameter int N = 4
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire pta_pkg::pta_cmd_t cmd,
    input wire logic rsp_valid,
    input wire logic cml_error,
    input wire logic [N-1:0] module_enabled,
    input wire logic [N*24-1:0] limit_pct
);
    // -----------------------------------------------------------
    // request decode
    // -----------------------------------------------------------
    wire take = cmd_valid && ce;
    wire rd = take && !cmd.wr;
    wire clr = take && cmd.wr && cmd.code == pta_pkg::CMD_CLEAR_FAULTS;
    wire nvw = take && cmd.wr && (cmd.code == 8'hD0 || cmd.code == 8'hD5
        || cmd.code == 8'hD7);
    wire refused = nvw && |module_enabled;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // -----------------------------------------------------------
    // properties
    // -----------------------------------------------------------
    a_read_answer: assert property (rd |=> rsp_valid)
        else $error("read not answered");
    a_answer_pulse: assert property (!rd |=> !rsp_valid)
        else $error("answer without read");
    a_refused_flag: assert property (refused |=> cml_error)
        else $error("refused write not flagged");
    a_refused_keep: assert property (refused |=> $stable(limit_pct))
        else $error("refused write changed limits");
    a_limit_ceiling: assert property (limit_pct[7:0] <= 8'h64)
        else $error("limit above full scale");
    a_error_sticky: assert property (cml_error && !clr |=> cml_error)
        else $error("error flag dropped");
    a_clear_error: assert property (clr |=> !cml_error)
        else $error("clear faults kept error");
    a_skip_byte: assert property (take && cmd.wr && cmd.code == 8'hD5
        && cmd.data[15:8] > 8'h64 |=> $stable(limit_pct[7:0]))
        else $error("skipped limit byte changed");
    c_read: cover property (rd ##1 rsp_valid);
    c_refused: cover property (refused ##1 cml_error);
    c_clear: cover property (clr && cml_error);
endmodule

bind pta_top pta_top_checker #(.N(N)) pta_top_checker_inst (.clk(clk),
    .arst_n(arst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid(rsp_valid), .cml_error(cml_error),
    .module_enabled(module_enabled), .limit_pct(limit_pct));

// >>> testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 4;
    localparam logic [15:0] VMAX = 16'h0186;
    localparam logic [15:0] IMAX = 16'h0023;
    logic clk = 0;
    logic link_clk = 0;
    logic arst_n = 0;
    logic cmd_valid = 0;
    logic go = 0;
    logic [N-1:0] enabled = 4'hF;
    logic [N-1:0] pin_n = 4'hF;
    logic [N-1:0] link_valid, start, uv_floor;
    pta_pkg::pta_telem_t tel [N];
    pta_pkg::pta_telem_t link_telem [N];
    pta_pkg::pta_cmd_t cmd = '0;
    logic [15:0] rsp_data;
    logic rsp_valid, cml_error;
    logic [N*24-1:0] limit_pct;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    always #62.5 link_clk = ~link_clk;
    pta_top #(.N(N), .SILENCE_CYCLES(50), .RATED_VIN_MAX(VMAX),
        .RATED_IOUT_MAX(IMAX)) pta_top_inst (.clk(clk), .arst_n(arst_n),
        .ce(1'b1), .link_clk(link_clk), .link_valid(link_valid),
        .link_telem(link_telem), .module_enabled(enabled),
        .enable_pin_n_raw(pin_n), .uv_ok_raw(4'hF), .cmd_valid(cmd_valid),
        .cmd(cmd), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
        .cml_error(cml_error), .module_start(start),
        .uv_floor_only(uv_floor), .limit_pct(limit_pct));
    pta_conv_model #(.N(N)) pta_conv_model_inst (.link_clk(link_clk),
        .go(go), .tel(tel), .link_valid(link_valid), .link_telem(link_telem));
    // -----------------------------------------------------------
    // tasks
    // -----------------------------------------------------------
    task automatic cmp(input string nm, input logic [95:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request is taken at the second edge; answer is looked at just after
    task automatic xfer(input logic w, logic [7:0] c, logic [47:0] d);
        @(posedge clk);
        cmd_valid <= 1;
        cmd <= '{c, d, w};
        @(posedge clk);
        cmd_valid <= 0;
        #1;
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e, m);
        xfer(0, c, '0);
        cmp("rsp_valid", 1, rsp_valid);
        cmp($sformatf("read %h", c), e, rsp_data & m);
    endtask
    task automatic link_send;
        @(posedge link_clk);
        go <= 1;
        @(posedge link_clk);
        go <= 0;
        repeat (3) @(posedge link_clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            test_done;
        end
    end
    // -----------------------------------------------------------
    // sequence; module 4 runs below zero to test signed max
    // -----------------------------------------------------------
    initial
    begin
        for (int i = 0; i < N; i++)
            tel[i] = '{16'h0180 + i, 16'h0010 + i, 16'h0030 + i, 16'h0100 + i,
                (i == 3) ? 16'hFFFB : 16'h0020 + i, 16'h0050 + i, 16'h0, 16'h0,
                i == 1, i == 2, 1'b0};
        repeat (3) @(posedge clk);
        arst_n <= 1;
        #1 cmp("limit_pct", {12{8'h64}}, limit_pct);
        link_send;
        xfer(1, pta_pkg::CMD_PAGE, 48'h01);
        rd(pta_pkg::CMD_INPUT_VOLTAGE_READING, 16'h0180, 16'hFFFF);
        rd(pta_pkg::CMD_OUTPUT_VOLTAGE_READING, 16'h0030, 16'hFFFF);
        rd(pta_pkg::CMD_RATED_INPUT_VOLTAGE_MAX, VMAX, 16'hFFFF);
        xfer(1, pta_pkg::CMD_PAGE, 48'h00);
        rd(pta_pkg::CMD_INPUT_CURRENT_READING, 16'h0046, 16'hFFFF);
        rd(pta_pkg::CMD_OUTPUT_CURRENT_READING, 16'h0406, 16'hFFFF);
        rd(pta_pkg::CMD_TEMPERATURE_READING, 16'h0022, 16'hFFFF);
        rd(pta_pkg::CMD_OUTPUT_POWER_READING, 16'h0146, 16'hFFFF);
        rd(pta_pkg::CMD_RATED_OUTPUT_CURRENT_MAX, IMAX * 4, 16'hFFFF);
        rd(pta_pkg::CMD_RATED_INPUT_VOLTAGE_MAX, VMAX, 16'hFFFF);
        rd(pta_pkg::CMD_VENDOR_FAULT_STATUS, 16'h00C0, 16'h00C0);
        $display("test telemetry done");
        repeat (60) @(posedge clk);
        rd(pta_pkg::CMD_VENDOR_FAULT_STATUS, 16'h0020, 16'h0020);
        link_send;
        rd(pta_pkg::CMD_VENDOR_FAULT_STATUS, 16'h0000, 16'h0020);
        $display("test link fault done");
        xfer(1, pta_pkg::CMD_COMBINED_LIMIT_WRITE, {6{8'h32}});
        cmp("cml_error", 1, cml_error);
        cmp("limit_pct", {12{8'h64}}, limit_pct);
        xfer(1, pta_pkg::CMD_CLEAR_FAULTS, '0);
        cmp("cml_error", 0, cml_error);
        $display("test refusal done");
        @(posedge clk);
        enabled <= '0;
        xfer(1, pta_pkg::CMD_PAGE, 48'hFF);
        xfer(1, pta_pkg::CMD_COMBINED_LIMIT_WRITE, {6{8'h50}});
        cmp("limit_pct", {12{8'h50}}, limit_pct);
        xfer(1, pta_pkg::CMD_COMBINED_LIMIT_WRITE, {6{8'h65}});
        cmp("limit_pct", {12{8'h50}}, limit_pct);
        xfer(1, pta_pkg::CMD_SUPERVISORY_FAULT_MASK, 48'h10);
        cmp("uv_floor", 4'hF, uv_floor);
        xfer(1, pta_pkg::CMD_PAGE, 48'h01);
        xfer(1, pta_pkg::CMD_ENABLE_INPUT_POLARITY, 48'h00);
        repeat (6) @(posedge clk);
        cmp("module_start", 4'hE, start);
        pin_n <= 4'hE;
        repeat (6) @(posedge clk);
        cmp("module_start", 4'hF, start);
        $display("test settings done");
        test_done;
    end
endmodule
